/* File: rtl/adc_cfg.svh */
`ifndef ADC_CFG_SVH
`define ADC_CFG_SVH

// converter clock and time conversion, times kept in microseconds
`define FCLK_HZ 64'd4915200
`define US_FLOOR(us) (((us) * `FCLK_HZ) / 64'd1000000)
`define US_CEIL(us) (((us) * `FCLK_HZ + 64'd999999) / 64'd1000000)

// core clock 25 MHz, converter tick 4.9152 MHz by phase accumulation
`define TICK_STEP 18'd49152
`define TICK_MOD 18'd250000

// conversion periods in converter clocks
`define DIV_FAST 64'd61440
`define DIV_SLOW 64'd491520

`define T_SETTLE_FAST_US 64'd51000
`define T_SETTLE_SLOW_US 64'd401000
`define T_CAL_FAST_US 64'd101280
`define T_CAL_SLOW_US 64'd801020
`define T_STBY_FAST_US 64'd12460
`define T_STBY_SLOW_US 64'd99960
`define T_WAKE_FAST_US 64'd52510
`define T_WAKE_SLOW_US 64'd401800
`define T_UPDATE_US 64'd39
`define UPDATE_CYC 24'(`US_CEIL(`T_UPDATE_US))

// serial frame
`define RES_W 24
`define RES_MSB 5'd23
`define EDGE_FORCE 5'd24
`define EDGE_READ 5'd25
`define EDGE_CAL 5'd26
`define EDGE_MAX 5'd31
`define DISCARD_N 3'd4

// host sclk half period, 3 cycles = 120 ns >= 100 ns
`define SCLK_HALF 2'd2

// host register map
`define REG_CTRL 4'h0
`define REG_CMD 4'h4
`define REG_STATUS 4'h8
`define REG_DATA 4'hc
`define CTRL_RATE 0
`define CTRL_CH_LOW 1
`define CTRL_CH_HIGH 2
`define CTRL_STBY 3
`define CMD_READ 0
`define CMD_CAL 1
`define CMD_DISCARD 2

`endif

/* File: rtl/adc_pkg.sv */
package adc_pkg;

typedef enum logic [4:0] {
    ST_CONVERT = 5'b00001,
    ST_SETTLE = 5'b00010,
    ST_CAL = 5'b00100,
    ST_STANDBY = 5'b01000,
    ST_WAKE = 5'b10000
} dev_state_e;

typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_WAIT = 4'b0010,
    H_HIGH = 4'b0100,
    H_LOW = 4'b1000
} host_state_e;

endpackage

/* File: rtl/adc_link_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface adc_link_if;
    logic sclk;
    logic ready_and_serial_out;
    logic rate_select;
    logic channel_select_low;
    logic channel_select_high;

    modport device (
        input sclk,
        input rate_select,
        input channel_select_low,
        input channel_select_high,
        output ready_and_serial_out
    );

    modport host (
        output sclk,
        output rate_select,
        output channel_select_low,
        output channel_select_high,
        input ready_and_serial_out
    );
endinterface

`default_nettype wire

/* File: rtl/adc_device.sv */
// Function
// [RQ1] channel toggle holds line high until settled
// [RQ2] host discards four readings after unseen jumps
// [RQ3] rate pin selects clock divided by 491520/61440
// [RQ4] result is 24-bit two's complement
// [RQ5] results saturate at full-scale codes
// [RQ6] line low flags data, first edge gives MSB
// [RQ7] next bits per edge, 25th edge forces high
// [RQ8] unread result overwritten after one period
// [RQ9] host avoids reading in update window
// [RQ10] line holds last bit until update starts
// [RQ11] 26th falling edge starts offset calibration
// [RQ12] calibration ends with ready after fixed time
// [RQ13] calibration disconnects inputs, applies internal signal
// [RQ14] host keeps sclk quiet during calibration
// [RQ15] sclk held high long enough enters standby
// [RQ16] host raises sclk within window after ready
// [RQ17] standby powers analog down, line high
// [RQ18] sclk low wakes, first result after delay
// [RQ19] standby accepted mid-readback
// [RQ20] all durations counted in converter clocks
// [RQ21] edge counter restarts at each new result
`timescale 1ns/1ps
`default_nettype none
`include "adc_cfg.svh"

module adc_device
    import adc_pkg::*;
#(
    parameter logic [23:0] CONV_FAST = 24'(`DIV_FAST),
    parameter logic [23:0] CONV_SLOW = 24'(`DIV_SLOW),
    parameter logic [23:0] SETTLE_FAST = 24'(`US_FLOOR(`T_SETTLE_FAST_US)),
    parameter logic [23:0] SETTLE_SLOW = 24'(`US_FLOOR(`T_SETTLE_SLOW_US)),
    parameter logic [23:0] CAL_FAST = 24'(`US_CEIL(`T_CAL_FAST_US)),
    parameter logic [23:0] CAL_SLOW = 24'(`US_CEIL(`T_CAL_SLOW_US)),
    parameter logic [23:0] STBY_FAST = 24'(`US_CEIL(`T_STBY_FAST_US)),
    parameter logic [23:0] STBY_SLOW = 24'(`US_CEIL(`T_STBY_SLOW_US)),
    parameter logic [23:0] WAKE_FAST = 24'(`US_FLOOR(`T_WAKE_FAST_US)),
    parameter logic [23:0] WAKE_SLOW = 24'(`US_FLOOR(`T_WAKE_SLOW_US))
) (
    input wire logic core_clk_in,
    input wire logic resetn_in,
    adc_link_if.device link,
    input wire logic signed [25:0] filter_value_in,
    output logic [23:0] result_out,
    output logic result_strobe_out,
    output logic cal_input_select_out,
    output logic analog_power_down_out
);

    dev_state_e state_reg;
    logic [17:0] acc_reg;
    logic tick_reg;
    logic [23:0] cnt_reg;
    logic [23:0] hold_reg;
    logic armed_reg;
    logic [1:0] ch_prev_reg;
    logic sclk_prev_reg;
    logic [4:0] edge_reg;
    logic line_reg;
    logic signed [25:0] offset_reg;
    logic [23:0] target_w;
    logic [23:0] period_w;
    logic [23:0] stby_w;
    logic new_data_w;
    logic chan_change_w;
    logic sclk_rise_w;
    logic sclk_fall_w;
    logic cal_start_w;
    logic standby_enter_w;
    logic update_start_w;

    // clip the offset-corrected filter value to the 24-bit code range
    function automatic logic [23:0] sat24(input logic signed [26:0] v);
        logic signed [26:0] top;
        logic signed [26:0] bot;
        top = 27'sh07fffff;
        bot = -27'sh0800000;
        if (v > top)
        begin
            sat24 = 24'h7fffff; // RQ5
        end
        else if (v < bot)
        begin
            sat24 = 24'h800000; // RQ5
        end
        else
        begin
            sat24 = v[23:0]; // RQ4
        end
    endfunction

    assign period_w = link.rate_select ? CONV_FAST : CONV_SLOW; // RQ3
    assign stby_w = link.rate_select ? STBY_FAST : STBY_SLOW;
    assign chan_change_w = ch_prev_reg != {link.channel_select_high, link.channel_select_low};
    assign sclk_rise_w = link.sclk & ~sclk_prev_reg;
    assign sclk_fall_w = ~link.sclk & sclk_prev_reg;
    assign cal_start_w = (state_reg == ST_CONVERT) && sclk_fall_w && (edge_reg == `EDGE_CAL); // RQ11
    assign standby_enter_w = (state_reg == ST_CONVERT) && armed_reg
        && link.sclk && (hold_reg >= stby_w); // RQ15 RQ19
    assign update_start_w = (state_reg == ST_CONVERT) && tick_reg
        && (cnt_reg == period_w - `UPDATE_CYC); // RQ10

    always_comb
    begin
        case (state_reg)
            ST_SETTLE: target_w = link.rate_select ? SETTLE_FAST : SETTLE_SLOW;
            ST_CAL: target_w = link.rate_select ? CAL_FAST : CAL_SLOW;
            ST_WAKE: target_w = link.rate_select ? WAKE_FAST : WAKE_SLOW;
            default: target_w = period_w;
        endcase
    end

    assign new_data_w = tick_reg && (state_reg != ST_STANDBY) && !chan_change_w
        && !cal_start_w && !standby_enter_w && (cnt_reg >= target_w - 24'd1);

    // converter clock as an enable, exact on average against 25 MHz
    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            acc_reg <= 18'h0;
            tick_reg <= 1'b0;
        end
        else if (19'(acc_reg) + 19'(`TICK_STEP) >= 19'(`TICK_MOD))
        begin
            acc_reg <= acc_reg + `TICK_STEP - `TICK_MOD;
            tick_reg <= 1'b1; // RQ20
        end
        else
        begin
            acc_reg <= acc_reg + `TICK_STEP;
            tick_reg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            ch_prev_reg <= 2'b00;
            sclk_prev_reg <= 1'b0;
        end
        else
        begin
            ch_prev_reg <= {link.channel_select_high, link.channel_select_low};
            sclk_prev_reg <= link.sclk;
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            state_reg <= ST_SETTLE;
            cnt_reg <= 24'h0;
        end
        else if (chan_change_w && state_reg != ST_STANDBY)
        begin
            state_reg <= ST_SETTLE; // RQ1
            cnt_reg <= 24'h0;
        end
        else if (cal_start_w)
        begin
            state_reg <= ST_CAL; // RQ11
            cnt_reg <= 24'h0;
        end
        else if (standby_enter_w)
        begin
            state_reg <= ST_STANDBY; // RQ15
            cnt_reg <= 24'h0;
        end
        else if (state_reg == ST_STANDBY)
        begin
            if (!link.sclk)
            begin
                state_reg <= ST_WAKE; // RQ18
            end
        end
        else if (new_data_w)
        begin
            state_reg <= ST_CONVERT; // RQ12 RQ18
            cnt_reg <= 24'h0;
        end
        else if (tick_reg)
        begin
            cnt_reg <= cnt_reg + 24'd1; // RQ20
        end
    end

    // inputs are reconnected at the end, so offset is sampled one conversion period into calibration
    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            offset_reg <= 26'sh0;
        end
        else if (state_reg == ST_CAL && tick_reg && cnt_reg == period_w)
        begin
            offset_reg <= filter_value_in; // RQ13
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            result_out <= 24'h0;
            result_strobe_out <= 1'b0;
        end
        else
        begin
            result_strobe_out <= new_data_w;
            if (new_data_w)
            begin
                // overwrites any result not yet read
                result_out <= sat24(27'(filter_value_in) - 27'(offset_reg)); // RQ8 RQ4
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            edge_reg <= 5'd0;
        end
        else if (new_data_w)
        begin
            edge_reg <= 5'd0; // RQ21
        end
        else if (sclk_rise_w && edge_reg != `EDGE_MAX)
        begin
            edge_reg <= edge_reg + 5'd1;
        end
    end

    // standby hold timer only counts after a result has been flagged
    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            armed_reg <= 1'b0;
            hold_reg <= 24'h0;
        end
        else
        begin
            if (new_data_w)
            begin
                armed_reg <= 1'b1;
            end
            else if (standby_enter_w || state_reg != ST_CONVERT)
            begin
                armed_reg <= 1'b0;
            end
            if (!link.sclk || !armed_reg)
            begin
                hold_reg <= 24'h0;
            end
            else if (tick_reg && hold_reg != 24'hffffff)
            begin
                hold_reg <= hold_reg + 24'd1; // RQ15
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            line_reg <= 1'b1;
        end
        else if (new_data_w)
        begin
            line_reg <= 1'b0; // RQ6 RQ1 RQ12
        end
        else if (chan_change_w || cal_start_w || update_start_w
            || state_reg != ST_CONVERT)
        begin
            line_reg <= 1'b1; // RQ1 RQ10 RQ17
        end
        else if (sclk_rise_w && edge_reg <= `RES_MSB)
        begin
            line_reg <= result_out[`RES_MSB - edge_reg]; // RQ6 RQ7
        end
        else if (sclk_rise_w && edge_reg == `EDGE_FORCE)
        begin
            line_reg <= 1'b1; // RQ7 RQ11
        end
    end

    assign link.ready_and_serial_out = line_reg;
    assign cal_input_select_out = state_reg == ST_CAL; // RQ13
    assign analog_power_down_out = state_reg == ST_STANDBY; // RQ17

endmodule

`default_nettype wire

/* File: rtl/adc_host.sv */
`timescale 1ns/1ps
`default_nettype none
`include "adc_cfg.svh"

module adc_host
    import adc_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic resetn_in,
    adc_link_if.host link,
    input wire logic [3:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out
);

    host_state_e state_reg;
    logic [3:0] ctrl_reg;
    logic sclk_reg;
    logic [1:0] ph_reg;
    logic [4:0] bits_reg;
    logic [4:0] need_reg;
    logic [23:0] shift_reg;
    logic [23:0] data_reg;
    logic [2:0] discard_reg;
    logic new_reg;
    logic done_w;
    logic cmd_w;

    assign cmd_w = wr_in && addr_in == `REG_CMD;
    assign done_w = state_reg == H_LOW && ph_reg == `SCLK_HALF
        && bits_reg + 5'd1 == need_reg;

    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            ctrl_reg <= 4'h0;
        end
        else if (wr_in && addr_in == `REG_CTRL)
        begin
            ctrl_reg <= wdata_in[3:0];
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            state_reg <= H_IDLE;
            sclk_reg <= 1'b0;
            ph_reg <= 2'd0;
            bits_reg <= 5'd0;
            need_reg <= 5'd0;
            shift_reg <= 24'h0;
        end
        else
        begin
            case (state_reg)
                H_IDLE:
                begin
                    // standby: raise as soon as ready shows, hold while set
                    sclk_reg <= ctrl_reg[`CTRL_STBY] && (sclk_reg || !link.ready_and_serial_out); // RQ16 RQ18
                    if (cmd_w && !ctrl_reg[`CTRL_STBY]
                        && (wdata_in[`CMD_READ] || wdata_in[`CMD_CAL]))
                    begin
                        need_reg <= wdata_in[`CMD_CAL] ? `EDGE_CAL : `EDGE_READ; // RQ11
                        bits_reg <= 5'd0;
                        state_reg <= H_WAIT;
                    end
                end
                H_WAIT:
                begin
                    // starting right at ready keeps clear of the update window
                    if (!link.ready_and_serial_out)
                    begin
                        sclk_reg <= 1'b1; // RQ9 RQ8
                        ph_reg <= 2'd0;
                        state_reg <= H_HIGH;
                    end
                end
                H_HIGH:
                begin
                    ph_reg <= ph_reg + 2'd1;
                    if (ph_reg == `SCLK_HALF)
                    begin
                        if (bits_reg <= `RES_MSB)
                        begin
                            shift_reg <= {shift_reg[22:0], link.ready_and_serial_out};
                        end
                        sclk_reg <= 1'b0;
                        ph_reg <= 2'd0;
                        state_reg <= H_LOW;
                    end
                end
                default:
                begin
                    ph_reg <= ph_reg + 2'd1;
                    if (ph_reg == `SCLK_HALF)
                    begin
                        bits_reg <= bits_reg + 5'd1;
                        ph_reg <= 2'd0;
                        if (done_w)
                        begin
                            // after a calibration request the host then idles quietly
                            state_reg <= H_IDLE; // RQ14
                        end
                        else
                        begin
                            sclk_reg <= 1'b1;
                            state_reg <= H_HIGH;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            data_reg <= 24'h0;
            discard_reg <= 3'd0;
            new_reg <= 1'b0;
        end
        else
        begin
            if (done_w)
            begin
                data_reg <= shift_reg;
            end
            if (cmd_w && wdata_in[`CMD_DISCARD])
            begin
                discard_reg <= `DISCARD_N; // RQ2
            end
            else if (done_w && discard_reg != 3'd0)
            begin
                discard_reg <= discard_reg - 3'd1; // RQ2
            end
            // set wins over the clear by reading data
            if (done_w)
            begin
                new_reg <= 1'b1;
            end
            else if (rd_in && addr_in == `REG_DATA)
            begin
                new_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rdata_out <= 32'h0;
        end
        else if (!rd_in)
        begin
            rdata_out <= 32'h0;
        end
        else if (addr_in == `REG_CTRL)
        begin
            rdata_out <= {28'h0, ctrl_reg};
        end
        else if (addr_in == `REG_STATUS)
        begin
            rdata_out <= {28'h0, new_reg, discard_reg == 3'd0,
                link.ready_and_serial_out, state_reg != H_IDLE};
        end
        else if (addr_in == `REG_DATA)
        begin
            rdata_out <= {8'h0, data_reg};
        end
        else
        begin
            rdata_out <= 32'h0;
        end
    end

    assign link.sclk = sclk_reg;
    assign link.rate_select = ctrl_reg[`CTRL_RATE];
    assign link.channel_select_low = ctrl_reg[`CTRL_CH_LOW];
    assign link.channel_select_high = ctrl_reg[`CTRL_CH_HIGH];

endmodule

`default_nettype wire

/* File: tb/adc_link_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

module adc_link_monitor #(
    parameter int CONV_FAST = 300,
    parameter int CONV_SLOW = 500,
    parameter int SETTLE_FAST = 400,
    parameter int SETTLE_SLOW = 600,
    parameter int CAL_FAST = 700,
    parameter int CAL_SLOW = 900,
    parameter int STBY = 250,
    parameter int WAKE = 400
) (
    input wire logic core_clk_in,
    input wire logic resetn_in,
    input wire logic sclk,
    input wire logic ready_and_serial_out,
    input wire logic rate_select,
    input wire logic channel_select_low,
    input wire logic channel_select_high
);
    // tick counts become core cycles; slack covers tick phase and pin latency
    localparam int TOL = 12;
    localparam int STBY_C = STBY * 250000 / 49152;
    localparam logic [2:0] K_NONE = 3'h0;
    localparam logic [2:0] K_CONV = 3'h1;
    localparam logic [2:0] K_SETTLE = 3'h2;
    localparam logic [2:0] K_CAL = 3'h3;
    localparam logic [2:0] K_WAKE = 3'h4;
    logic line_q, sclk_q, chl_q, chh_q, rate_q, ready, rose_sclk, chan_chg;
    logic [4:0] rise_cnt;
    logic [15:0] hi_cnt;
    logic [2:0] kind;
    int tmr, exp_tk, exp_cyc;

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!resetn_in);

    // a fall while sclk is low is a ready; data bits only move with sclk high
    assign ready = line_q && !ready_and_serial_out && !sclk;
    assign rose_sclk = sclk && !sclk_q;
    assign chan_chg = (chl_q != channel_select_low) || (chh_q != channel_select_high);

    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            line_q <= 1'b1;
            sclk_q <= 1'b0;
            chl_q <= 1'b0;
            chh_q <= 1'b0;
            rate_q <= 1'b0;
        end
        else
        begin
            line_q <= ready_and_serial_out;
            sclk_q <= sclk;
            chl_q <= channel_select_low;
            chh_q <= channel_select_high;
            rate_q <= rate_select;
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            rise_cnt <= 5'h0;
        else if (ready)
            rise_cnt <= 5'h0;
        else if (rose_sclk && rise_cnt != 5'h1f)
            rise_cnt <= rise_cnt + 5'h1;
    end

    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            hi_cnt <= 16'h0;
        else if (!sclk)
            hi_cnt <= 16'h0;
        else if (hi_cnt != 16'hffff)
            hi_cnt <= hi_cnt + 16'h1;
    end

    // the device leaves reset settling, so the first wait is a settle
    always_ff @(posedge core_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            kind <= K_SETTLE;
            tmr <= 0;
        end
        else if (chan_chg)
        begin
            kind <= K_SETTLE;
            tmr <= 0;
        end
        else if (rate_select != rate_q)
            kind <= K_NONE;
        else if (ready)
        begin
            kind <= K_CONV;
            tmr <= 0;
        end
        else if (!sclk && sclk_q && rise_cnt == 5'd26)
        begin
            kind <= K_CAL;
            tmr <= 0;
        end
        else if (!sclk && sclk_q && int'(hi_cnt) > STBY_C)
        begin
            kind <= K_WAKE;
            tmr <= 0;
        end
        else if (hi_cnt == 16'h10)
            kind <= K_NONE;
        else
            tmr <= tmr + 1;
    end

    always_comb
    begin
        case (kind)
            K_CONV: exp_tk = rate_select ? CONV_FAST : CONV_SLOW;
            K_SETTLE: exp_tk = rate_select ? SETTLE_FAST : SETTLE_SLOW;
            K_CAL: exp_tk = rate_select ? CAL_FAST : CAL_SLOW;
            K_WAKE: exp_tk = WAKE;
            default: exp_tk = 0;
        endcase
        exp_cyc = exp_tk * 250000 / 49152;
    end

    chk_settle_time: assert property (ready && kind == K_SETTLE |->
        tmr >= exp_cyc - TOL && tmr <= exp_cyc + TOL) else $error("settle time off");
    chk_chan_high: assert property (chan_chg |-> ##3 ready_and_serial_out [*8])
        else $error("line not high after channel change");
    chk_conv_period: assert property (ready && kind == K_CONV |->
        tmr >= exp_cyc - TOL && tmr <= exp_cyc + TOL) else $error("conversion period off");
    chk_cal_time: assert property (ready && kind == K_CAL |->
        tmr >= exp_cyc - TOL && tmr <= exp_cyc + TOL) else $error("calibration time off");
    chk_wake_time: assert property (ready && kind == K_WAKE |->
        tmr >= exp_cyc - TOL && tmr <= exp_cyc + TOL) else $error("wake time off");
    chk_ready_deadline: assert property (kind != K_NONE |-> tmr <= exp_cyc + TOL)
        else $error("ready overdue");
    chk_force_high: assert property (rose_sclk && rise_cnt == 5'd24 |->
        ##3 ready_and_serial_out [*4]) else $error("extra edge did not force high");
    chk_bit_hold: assert property (rose_sclk && rise_cnt < 5'd24 |->
        ##4 $stable(ready_and_serial_out) [*2]) else $error("data bit moved");
    chk_cal_holds_high: assert property (kind == K_CAL && !ready |-> ready_and_serial_out)
        else $error("line low during calibration");
    chk_standby_high: assert property (sclk && int'(hi_cnt) > STBY_C + TOL |->
        ready_and_serial_out) else $error("line low in standby");

    cover property (ready && kind == K_CAL);
    cover property (ready && kind == K_WAKE);
    cover property (rose_sclk && rise_cnt == 5'd24);
    cover property (ready && kind == K_SETTLE && rate_select);
endmodule

`default_nettype wire

/* File: tb/tb_bridge_adc_serial_readout.sv */
`timescale 1ns/1ps
`default_nettype none
`include "adc_cfg.svh"
`define CHECK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
    $display("Error at %0t ns: got %h expected %h", $time, (a), (b)); end end

module tb_bridge_adc_serial_readout;
    // shortened tick counts keep the run short; cal must outlast a conversion
    localparam int CF = 300, CS = 500, SF = 400, SS = 600, KF = 700, KS = 900, BY = 250, WK = 400;
    logic core_clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic wr = 1'b0, rd = 1'b0;
    logic signed [25:0] filt = 26'sh0;
    logic [23:0] result;
    logic rstrobe, cal_sel, pdown;
    int n_fail = 0, compares = 0, seed = 75, offset = 0;
    logic signed [25:0] vals [9] = '{26'sh0, -26'sh1, 26'sh1, 26'sh7fffff, 26'sh800000,
        -26'sh800000, -26'sh800001, 26'sh1ffffff, -26'sh2000000};

    adc_link_if link ();
    adc_device #(.CONV_FAST(24'(CF)), .CONV_SLOW(24'(CS)), .SETTLE_FAST(24'(SF)),
        .SETTLE_SLOW(24'(SS)), .CAL_FAST(24'(KF)), .CAL_SLOW(24'(KS)), .STBY_FAST(24'(BY)),
        .STBY_SLOW(24'(BY)), .WAKE_FAST(24'(WK)), .WAKE_SLOW(24'(WK))) adc_device_inst (
        .core_clk_in(core_clk_in), .resetn_in(resetn_in), .link(link),
        .filter_value_in(filt), .result_out(result), .result_strobe_out(rstrobe),
        .cal_input_select_out(cal_sel), .analog_power_down_out(pdown));
    adc_host adc_host_inst (.core_clk_in(core_clk_in), .resetn_in(resetn_in), .link(link),
        .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata));
    adc_link_monitor #(.CONV_FAST(CF), .CONV_SLOW(CS), .SETTLE_FAST(SF), .SETTLE_SLOW(SS),
        .CAL_FAST(KF), .CAL_SLOW(KS), .STBY(BY), .WAKE(WK)) adc_link_monitor_inst (
        .core_clk_in(core_clk_in), .resetn_in(resetn_in), .sclk(link.sclk),
        .ready_and_serial_out(link.ready_and_serial_out), .rate_select(link.rate_select),
        .channel_select_low(link.channel_select_low),
        .channel_select_high(link.channel_select_high));

    always #20 core_clk_in = ~core_clk_in;

    task automatic end_of_test();
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge core_clk_in);
        wr <= 1'b0;
    endtask

    task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge core_clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk_in);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    // waits for the line to be high, then for the next fall; ticks 0 skips timing
    task automatic ready_after(input int ticks);
        int n;
        int e;
        n = 0;
        e = ticks * 250000 / 49152;
        while (link.ready_and_serial_out !== 1'b1 && n < 30000)
        begin
            @(negedge core_clk_in);
            n++;
        end
        while (link.ready_and_serial_out !== 1'b0 && n < 30000)
        begin
            @(negedge core_clk_in);
            n++;
        end
        if (ticks > 0)
            `CHECK(n >= e - 12 && n <= e + 12, 1'b1)
    endtask

    task automatic sample(input logic signed [25:0] v, input logic chk_new);
        logic [31:0] d;
        int m;
        logic [23:0] x;
        @(posedge core_clk_in);
        filt <= v;
        ready_after(0);
        `CHECK(rstrobe, 1'b1)
        bus_wr(`REG_CMD, 32'h1);
        for (int k = 0; k < 100; k++)
        begin
            bus_rd(`REG_STATUS, d);
            if (d[0] === 1'b0)
                break;
        end
        m = v - offset;
        x = m > 8388607 ? 24'h7fffff : (m < -8388608 ? 24'h800000 : m[23:0]);
        if (chk_new)
            `CHECK(d[3], 1'b1)
        bus_rd(`REG_DATA, d);
        `CHECK(d[23:0], x)
        `CHECK(result, x)
    endtask
    initial
    begin
        #3200000;
        n_fail++;
        end_of_test();
    end

    initial
    begin
        logic [31:0] d;
        int v;
        repeat (12) @(posedge core_clk_in);
        `CHECK(link.ready_and_serial_out, 1'b1)
        resetn_in <= 1'b1;
        ready_after(SS);
        bus_rd(4'h2, d);
        `CHECK(d, 32'h0)
        bus_wr(`REG_CTRL, 32'h1);
        ready_after(0);
        ready_after(CF);
        foreach (vals[i])
            sample(vals[i], 1'b1);
        repeat (3)
            sample(26'($random(seed)), 1'b1);
        bus_wr(`REG_CTRL, 32'h3);
        ready_after(SF);
        bus_wr(`REG_CTRL, 32'h7);
        ready_after(SF);
        bus_wr(`REG_CMD, 32'h4);
        bus_rd(`REG_STATUS, d);
        `CHECK(d[2], 1'b0)
        repeat (4)
            sample(26'($random(seed)), 1'b0);
        bus_rd(`REG_STATUS, d);
        `CHECK(d[2], 1'b1)
        v = $random(seed) % 1000;
        @(posedge core_clk_in);
        filt <= 26'(v);
        bus_wr(`REG_CMD, 32'h2);
        repeat (26) @(posedge link.sclk);
        @(negedge link.sclk);
        repeat (3) @(negedge core_clk_in);
        `CHECK(cal_sel, 1'b1)
        ready_after(KF);
        `CHECK(cal_sel, 1'b0)
        offset = v;
        sample(26'(v + 77), 1'b1);
        sample(-26'sh2000000, 1'b1);
        bus_wr(`REG_CTRL, 32'hf);
        for (int k = 0; k < 6000 && pdown !== 1'b1; k++)
            @(negedge core_clk_in);
        `CHECK(pdown, 1'b1)
        `CHECK(link.ready_and_serial_out, 1'b1)
        bus_wr(`REG_CTRL, 32'h7);
        wait (link.sclk === 1'b0);
        ready_after(WK);
        `CHECK(pdown, 1'b0)
        bus_wr(`REG_CTRL, 32'h6);
        ready_after(0);
        ready_after(CS);
        sample(26'sh12345, 1'b1);
        end_of_test();
    end
endmodule

`default_nettype wire
